// >>> rtl/apw_axis_channel.sv
`timescale 1ns/1ps
module apw_axis_channel
  import apw_pkg::*;
#(
  parameter int PER_W = 16
) (
  input  logic                mclk,
  input  logic                rstn,
  input  logic                ce,
  input  logic                phase_tick,
  input  logic                servo_tick,
  input  apw_chan_cfg_t       chan_cfg,
  input  apw_adc_cfg_t        adc_cfg,
  input  apw_pfm_cfg_t        pfm_cfg,
  input  logic [31:0]         pwm_cmd_a,
  input  logic [31:0]         pwm_cmd_b,
  input  logic [31:0]         pwm_cmd_c,
  input  logic [31:0]         pwm_cmd_d,
  input  logic [31:0]         pfm_word,
  output apw_gate_t [3:0]     phase_gate,
  output logic                aux_pulse,
  output logic                aux_dir,
  output logic                adc_clk,
  output logic                adc_strobe,
  input  logic                adc_data_a,
  input  logic                adc_data_b,
  output logic [31:0]         feedback_a,
  output logic [31:0]         feedback_b,
  output logic                feedback_valid,
  output logic [31:0]         timer_count_value,
  output logic [31:0]         servo_latched_position
);

  if (PER_W < 8 || PER_W > 24) begin : g_chk
    $error("PER_W must be 8 to 24");
  end

  // ---------------- PWM carrier ----------------
  logic [PER_W-1:0] per_cnt_reg;
  logic [PER_W-1:0] per_reg;
  logic [PER_W-1:0] car_reg;
  logic             car_down_reg;
  logic [PER_W-1:0] car_step;

  // Triangle amplitude equals the phase period, step n+1: period 2T/(n+1)
  assign car_step = PER_W'({1'b0, chan_cfg.pwm_rate_multiplier} + 4'h1);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      per_cnt_reg <= '0;
      per_reg     <= '0;
    end else if (ce) begin
      if (phase_tick) begin
        per_reg     <= per_cnt_reg;
        per_cnt_reg <= PER_W'(1);
      end else if (per_cnt_reg != '1) begin
        per_cnt_reg <= per_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      car_reg      <= '0;
      car_down_reg <= 1'b0;
    end else if (ce) begin
      if (!car_down_reg) begin
        if ({1'b0, car_reg} + {1'b0, car_step} >= {1'b0, per_reg}) begin
          car_reg      <= per_reg;
          car_down_reg <= 1'b1;
        end else begin
          car_reg <= car_reg + car_step;
        end
      end else if (car_reg <= car_step) begin
        car_reg      <= '0;
        car_down_reg <= 1'b0;
      end else begin
        car_reg <= car_reg - car_step;
      end
    end
  end

  // Signed command to a carrier-scale threshold
  function automatic logic [PER_W-1:0] duty_level(input logic [15:0] cmd, input logic [PER_W-1:0] per);
    logic [PER_W+15:0] prod;
    prod = (PER_W+16)'({~cmd[15], cmd[14:0]}) * (PER_W+16)'(per);
    return prod[PER_W+15:16];
  endfunction

  logic [3:0][15:0] cmd_ph;
  assign cmd_ph[0] = pwm_cmd_a[31:16];
  assign cmd_ph[1] = pwm_cmd_b[31:16];
  assign cmd_ph[2] = chan_cfg.command_pairing_enable ? pwm_cmd_a[15:0] : pwm_cmd_c[31:16];
  assign cmd_ph[3] = chan_cfg.command_pairing_enable ? pwm_cmd_b[15:0] : pwm_cmd_d[31:16];

  apw_gate_t [3:0] gate_raw;

  // A set mode bit takes its phase out of PWM (DAC or pulse use)
  for (genvar gi = 0; gi < 4; gi++) begin : g_phase
    apw_gap_gen u_gap (
      .mclk      (mclk),
      .rstn      (rstn),
      .ce        (ce),
      .want_on   (duty_level(cmd_ph[gi], per_reg) > car_reg),
      .enable    (~chan_cfg.phase_output_select[gi]),
      .gap_units (chan_cfg.switch_gap_time),
      .gate_out  (gate_raw[gi])
    );
  end

  // ---------------- Pulse generator ----------------
  logic [23:0] pfm_rate;
  logic [23:0] pfm_mag;
  logic [24:0] acc_sum;
  logic [23:0] acc_reg;
  logic        step_reg;
  logic        dir_up_reg;
  logic [1:0]  qc_reg;
  logic        pulse_line;
  logic        dir_line;

  assign pfm_rate = chan_cfg.command_pairing_enable ? {{8{pwm_cmd_b[15]}}, pwm_cmd_b[15:0]}
                                                     : pfm_word[31:8];
  assign pfm_mag  = pfm_rate[23] ? (~pfm_rate + 24'h00_0001) : pfm_rate;
  assign acc_sum  = {1'b0, acc_reg} + {1'b0, pfm_mag};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      acc_reg    <= ACC_RST;
      step_reg   <= 1'b0;
      dir_up_reg <= 1'b1;
    end else if (ce) begin
      acc_reg    <= acc_sum[23:0];
      step_reg   <= acc_sum[24];
      dir_up_reg <= ~pfm_rate[23];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      qc_reg <= 2'h0;
    end else if (ce && step_reg) begin
      qc_reg <= dir_up_reg ? qc_reg + 2'h1 : qc_reg - 2'h1;
    end
  end

  // Square wave at the step rate; quadrature is a Gray count of steps
  assign pulse_line = (pfm_cfg.pulse_gen_format ? qc_reg[1] : acc_reg[23])
                      ^ chan_cfg.phase_polarity_invert[POL_D_BIT];
  assign dir_line   = pfm_cfg.pulse_gen_format ? (qc_reg[1] ^ qc_reg[0])
                                               : (dir_up_reg ^ pfm_cfg.direction_sense_invert);

  // ---------------- Phase outputs ----------------
  apw_gate_t [3:0] phase_gate_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phase_gate_reg <= '0;
    end else if (ce) begin
      for (int i = 0; i < 3; i++) begin
        phase_gate_reg[i] <= gate_raw[i] ^ {2{chan_cfg.phase_polarity_invert[POL_AC_BIT]}};
      end
      if (chan_cfg.phase_output_select[MODE_PFM_BIT]) begin
        phase_gate_reg[3] <= {pulse_line, dir_line};
      end else begin
        phase_gate_reg[3] <= gate_raw[3] ^ {2{chan_cfg.phase_polarity_invert[POL_D_BIT]}};
      end
    end
  end

  assign phase_gate = phase_gate_reg;

  // Aux enable is a live input; the aux outputs come up low after every reset
  logic aux_pulse_reg;
  logic aux_dir_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aux_pulse_reg <= 1'b0;
      aux_dir_reg   <= 1'b0;
    end else if (ce) begin
      aux_pulse_reg <= pfm_cfg.aux_line_pulse_enable & pulse_line;
      aux_dir_reg   <= pfm_cfg.aux_line_pulse_enable & dir_line;
    end
  end

  assign aux_pulse = aux_pulse_reg;
  assign aux_dir   = aux_dir_reg;

  // ---------------- Pulse counting ----------------
  logic [31:0] timer_reg;
  logic [31:0] enc_reg;
  logic [31:0] latch_reg;
  logic [31:0] count_delta;
  logic [7:0]  frac_now;

  assign count_delta = dir_up_reg ? 32'h0000_0001 : 32'hffff_ffff;
  // Accumulator phase is the timer-style fraction of the next step
  assign frac_now    = (pfm_cfg.channel_timer_function == TMR_FRAC_EST)
                       ? (dir_up_reg ? acc_reg[23:16] : ~acc_reg[23:16]) : FRAC_HALF;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      timer_reg <= COUNT_RST;
    end else if (ce && step_reg && pfm_cfg.channel_timer_function == TMR_PULSE_COUNT) begin
      timer_reg <= timer_reg + count_delta;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      enc_reg <= COUNT_RST;
    end else if (ce && step_reg && pfm_cfg.quad_decoder_control == ENC_FROM_PULSE) begin
      enc_reg <= enc_reg + count_delta;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      latch_reg <= COUNT_RST;
    end else if (ce && servo_tick) begin
      latch_reg <= {enc_reg[23:0], frac_now};
    end
  end

  assign timer_count_value      = timer_reg;
  assign servo_latched_position = latch_reg;

  // ---------------- Feedback sampler link ----------------
  typedef enum logic [2:0] {
    AD_IDLE  = 3'b001,
    AD_LAG   = 3'b010,
    AD_SHIFT = 3'b100
  } apw_adc_state_t;

  apw_adc_state_t ad_state_reg;
  logic [7:0]     lag_cnt_reg;
  logic [4:0]     half_cnt_reg;
  logic [4:0]     bit_idx_reg;
  logic [4:0]     bit_nxt;
  logic [4:0]     half_len;
  logic [2:0]     div_eff;
  logic           adc_clk_reg;
  logic           adc_strobe_reg;
  logic           ad_done_reg;
  logic [15:0]    sr_a_reg;
  logic [15:0]    sr_b_reg;
  logic           in_window;

  // Dividers below the minimum cannot be met at this clock; clamped
  assign div_eff   = (adc_cfg.sampler_bitclock_divider < BITDIV_MIN) ? BITDIV_MIN
                                                                      : adc_cfg.sampler_bitclock_divider;
  assign half_len  = 5'h01 << (div_eff - BITDIV_MIN);
  assign bit_nxt   = bit_idx_reg + 5'h01;
  assign in_window = (bit_idx_reg >= {1'b0, adc_cfg.sampler_leading_skip}) &&
                     (bit_idx_reg < {1'b0, adc_cfg.sampler_leading_skip} + 5'(SAMPLE_BITS));

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ad_state_reg   <= AD_IDLE;
      lag_cnt_reg    <= 8'h00;
      half_cnt_reg   <= 5'h00;
      bit_idx_reg    <= 5'h00;
      adc_clk_reg    <= 1'b0;
      adc_strobe_reg <= 1'b0;
      ad_done_reg    <= 1'b0;
      sr_a_reg       <= 16'h0000;
      sr_b_reg       <= 16'h0000;
    end else if (ce) begin
      ad_done_reg <= 1'b0;
      case (ad_state_reg)
        AD_IDLE: begin
          adc_clk_reg    <= 1'b0;
          adc_strobe_reg <= 1'b0;
          if (phase_tick) begin
            lag_cnt_reg  <= adc_cfg.sampler_strobe_lag;
            ad_state_reg <= AD_LAG;
          end
        end
        AD_LAG: begin
          if (lag_cnt_reg == 8'h00) begin
            ad_state_reg   <= AD_SHIFT;
            bit_idx_reg    <= 5'h00;
            half_cnt_reg   <= 5'h00;
            adc_strobe_reg <= adc_cfg.sampler_frame_word[FRAME_BITS-1];
          end else begin
            lag_cnt_reg <= lag_cnt_reg - 8'h01;
          end
        end
        AD_SHIFT: begin
          if (half_cnt_reg == half_len - 5'h01) begin
            half_cnt_reg <= 5'h00;
            if (!adc_clk_reg) begin
              adc_clk_reg <= 1'b1;
              if (in_window) begin
                sr_a_reg <= {sr_a_reg[14:0], adc_data_a};
                sr_b_reg <= {sr_b_reg[14:0], adc_data_b};
              end
            end else begin
              adc_clk_reg <= 1'b0;
              if (bit_idx_reg == 5'(FRAME_BITS - 1)) begin
                ad_state_reg   <= AD_IDLE;
                adc_strobe_reg <= 1'b0;
                ad_done_reg    <= 1'b1;
              end else begin
                bit_idx_reg    <= bit_nxt;
                adc_strobe_reg <= adc_cfg.sampler_frame_word[5'(FRAME_BITS - 1) - bit_nxt];
              end
            end
          end else begin
            half_cnt_reg <= half_cnt_reg + 5'h01;
          end
        end
        default: ad_state_reg <= AD_IDLE;
      endcase
    end
  end

  logic [15:0] samp_a;
  logic [15:0] samp_b;
  logic [31:0] feedback_a_reg;
  logic [31:0] feedback_b_reg;
  logic        feedback_valid_reg;

  assign samp_a = sr_a_reg ^ (adc_cfg.sampler_sign_convert ? SIGN_FLIP : 16'h0000);
  assign samp_b = sr_b_reg ^ (adc_cfg.sampler_sign_convert ? SIGN_FLIP : 16'h0000);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      feedback_a_reg     <= COUNT_RST;
      feedback_b_reg     <= COUNT_RST;
      feedback_valid_reg <= 1'b0;
    end else if (ce) begin
      feedback_valid_reg <= ad_done_reg;
      if (ad_done_reg) begin
        feedback_a_reg <= chan_cfg.feedback_pairing_enable ? {samp_a, samp_b} : {samp_a, 16'h0000};
        feedback_b_reg <= {samp_b, 16'h0000};
      end
    end
  end

  assign adc_clk        = adc_clk_reg;
  assign adc_strobe     = adc_strobe_reg;
  assign feedback_a     = feedback_a_reg;
  assign feedback_b     = feedback_b_reg;
  assign feedback_valid = feedback_valid_reg;

  // ---------------- Checks ----------------
  AST_MODE_OFF: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && chan_cfg.phase_output_select[0] && !chan_cfg.phase_polarity_invert[POL_AC_BIT])[*3]
    |-> (phase_gate_reg[0] == 2'b00)) else $error("Non-PWM phase A still driven");

  AST_POL_D: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && chan_cfg.phase_output_select[MODE_PFM_BIT])
    |=> (phase_gate_reg[3].hi == $past(pulse_line))) else $error("Phase D pulse line wrong");

  AST_TIMER_COUNT: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && step_reg && dir_up_reg && pfm_cfg.channel_timer_function == TMR_PULSE_COUNT)
    |=> (timer_reg == $past(timer_reg) + 32'h0000_0001)) else $error("Pulse not counted");

  AST_ENC_COUNT: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && step_reg && !dir_up_reg && pfm_cfg.quad_decoder_control == ENC_FROM_PULSE)
    |=> (enc_reg == $past(enc_reg) - 32'h0000_0001)) else $error("Decoder count wrong");

  AST_FRAC_HALF: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && servo_tick && pfm_cfg.channel_timer_function == TMR_PULSE_COUNT)
    |=> (latch_reg[7:0] == FRAC_HALF && latch_reg[31:8] == $past(enc_reg[23:0])))
    else $error("Latched fraction not one half");

  AST_LAG_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && ad_state_reg == AD_IDLE && phase_tick && adc_cfg.sampler_strobe_lag == 8'h00) ##1 ce
    |=> (ad_state_reg == AD_SHIFT)) else $error("Strobe delayed with zero lag");

  AST_FRAME_BIT: assert property (@(posedge mclk) disable iff (!rstn)
    (ad_state_reg == AD_SHIFT)
    |-> (adc_strobe_reg == adc_cfg.sampler_frame_word[5'(FRAME_BITS - 1) - bit_idx_reg]))
    else $error("Strobe bit differs from frame word");

  AST_FB_PACK: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && ad_done_reg && chan_cfg.feedback_pairing_enable)
    |=> (feedback_a_reg[15:0] == feedback_b_reg[31:16] && feedback_valid_reg))
    else $error("Paired feedback mismatch");

  AST_SIGN_CONV: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && ad_done_reg && adc_cfg.sampler_sign_convert)
    |=> (feedback_b_reg[31] == ~$past(sr_b_reg[15]))) else $error("Sample not sign converted");

  AST_AUX_OFF: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && !pfm_cfg.aux_line_pulse_enable) |=> (!aux_pulse_reg && !aux_dir_reg))
    else $error("Aux lines active while disabled");

endmodule // apw_axis_channel

// >>> rtl/apw_gap_gen.sv
`timescale 1ns/1ps
module apw_gap_gen
  import apw_pkg::*;
(
  input  logic       mclk,
  input  logic       rstn,
  input  logic       ce,
  input  logic       want_on,
  input  logic       enable,
  input  logic [7:0] gap_units,
  output apw_gate_t  gate_out
);

  typedef enum logic [2:0] {
    GP_GAP = 3'b001,
    GP_HI  = 3'b010,
    GP_LO  = 3'b100
  } apw_gap_state_t;

  apw_gap_state_t state_reg;
  logic [23:0]    elapsed_reg;
  logic [23:0]    target_ps;

  assign target_ps = 24'(gap_units * 24'(DEAD_UNIT_PS));

  // Every switch passes through the gap state, so both sides are never on
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= GP_GAP;
      elapsed_reg <= 24'h00_0000;
    end else if (ce) begin
      case (state_reg)
        GP_GAP: begin
          // Stops counting once at or past target so a long idle cannot wrap and stretch the gap
          if (elapsed_reg < target_ps) begin
            elapsed_reg <= elapsed_reg + 24'(CLK_PERIOD_PS);
          end
          if (enable && elapsed_reg >= target_ps) begin
            state_reg <= want_on ? GP_HI : GP_LO;
          end
        end
        GP_HI: begin
          if (!(enable && want_on)) begin
            state_reg   <= GP_GAP;
            elapsed_reg <= 24'(CLK_PERIOD_PS);
          end
        end
        GP_LO: begin
          if (!(enable && !want_on)) begin
            state_reg   <= GP_GAP;
            elapsed_reg <= 24'(CLK_PERIOD_PS);
          end
        end
        default: begin
          state_reg   <= GP_GAP;
          elapsed_reg <= 24'(CLK_PERIOD_PS);
        end
      endcase
    end
  end

  assign gate_out.hi = (state_reg == GP_HI);
  assign gate_out.lo = (state_reg == GP_LO);

  AST_NO_OVERLAP: assert property (@(posedge mclk) disable iff (!rstn)
    !(gate_out.hi && gate_out.lo)) else $error("Both drives of a phase on");

  AST_GAP_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
    (state_reg == GP_GAP && elapsed_reg < target_ps) |=> (state_reg == GP_GAP))
    else $error("Gap ended before the programmed time");

  AST_HI_TO_GAP: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && gate_out.hi && !want_on) |=> (!gate_out.hi && !gate_out.lo))
    else $error("Complement switched on without a gap");

endmodule // apw_gap_gen

// >>> rtl/apw_pkg.sv
package apw_pkg;

  // Timing base
  localparam int CLK_PERIOD_PS   = 40000;
  localparam int DEAD_UNIT_PS    = 53330;
  localparam int INT_CLK_MHZ     = 100;
  localparam int MCLK_MHZ        = 25;
  localparam int ICLK_PER_MCLK   = INT_CLK_MHZ / MCLK_MHZ;
  // Smallest divider whose half bit period is a whole mclk cycle
  localparam logic [2:0] BITDIV_MIN = 3'($clog2(2 * ICLK_PER_MCLK));

  // Phase output select and polarity field positions
  localparam int MODE_PFM_BIT    = 3;
  localparam int POL_AC_BIT      = 0;
  localparam int POL_D_BIT       = 1;

  // Serial sampler framing
  localparam int FRAME_BITS      = 24;
  localparam int SAMPLE_BITS     = 16;
  localparam logic [15:0] SIGN_FLIP = 16'h8000;

  // Pulse counting and latch
  localparam logic [2:0] TMR_FRAC_EST    = 3'h0;
  localparam logic [2:0] TMR_PULSE_COUNT = 3'h3;
  localparam logic [3:0] ENC_FROM_PULSE  = 4'h8;
  localparam logic [7:0] FRAC_HALF       = 8'h80;

  // Reset values
  localparam logic [31:0] COUNT_RST      = 32'h0000_0000;
  localparam logic [23:0] ACC_RST        = 24'h00_0000;

  typedef struct packed {
    logic [3:0] phase_output_select;
    logic [1:0] phase_polarity_invert;
    logic [2:0] pwm_rate_multiplier;
    logic [7:0] switch_gap_time;
    logic       command_pairing_enable;
    logic       feedback_pairing_enable;
  } apw_chan_cfg_t;

  typedef struct packed {
    logic [2:0]  sampler_bitclock_divider;
    logic [23:0] sampler_frame_word;
    logic [3:0]  sampler_leading_skip;
    logic        sampler_sign_convert;
    logic [7:0]  sampler_strobe_lag;
  } apw_adc_cfg_t;

  typedef struct packed {
    logic       pulse_gen_format;
    logic       direction_sense_invert;
    logic [2:0] channel_timer_function;
    logic [3:0] quad_decoder_control;
    logic       aux_line_pulse_enable;
  } apw_pfm_cfg_t;

  typedef struct packed {
    logic hi;
    logic lo;
  } apw_gate_t;

endpackage

// >>> tb/apw_adc_model.sv
`timescale 1ns/1ps
module apw_adc_model (
  input  wire logic        adc_clk,
  input  wire logic        frame_start,
  input  wire logic [3:0]  skip,
  input  wire logic [15:0] smp_a,
  input  wire logic [15:0] smp_b,
  output logic             adc_data_a,
  output logic             adc_data_b
);
  int idx = 0;
  // Header and tail oppose the sample MSB, so a wrong skip shows
  function automatic logic pick(logic [15:0] s, int i, int k);
    return (i >= k && i < k + 16) ? s[15 - i + k] : ~s[15];
  endfunction
  always @(posedge frame_start) idx = 0;
  // Move on just after the edge that the sampler uses
  always @(posedge adc_clk) idx <= #1 idx + 1;
  assign adc_data_a = pick(smp_a, idx, skip);
  assign adc_data_b = pick(smp_b, idx, skip);
endmodule // apw_adc_model

// >>> tb/apw_axis_channel_bench.sv
`timescale 1ns/1ps
module apw_axis_channel_bench import apw_pkg::*;;
  logic            mclk, rstn, ce, phase_tick, servo_tick, ms_start;
  logic            adc_clk, adc_strobe, dat_a, dat_b, feedback_valid, aux_pulse, aux_dir;
  apw_chan_cfg_t   cc;
  apw_adc_cfg_t    ac;
  apw_pfm_cfg_t    pc;
  logic [31:0]     cmd_a, cmd_b, cmd_c, cmd_d, pfm_word, fb_a, fb_b, tmr, pos;
  apw_gate_t [3:0] gate;
  int              err_total, checks;
  localparam logic [15:0] SMP_A = 16'h9a5c;
  localparam logic [15:0] SMP_B = 16'h3c71;

  apw_axis_channel i_apw_axis_channel (.mclk(mclk), .rstn(rstn), .ce(ce), .phase_tick(phase_tick),
    .servo_tick(servo_tick), .chan_cfg(cc), .adc_cfg(ac), .pfm_cfg(pc), .pwm_cmd_a(cmd_a), .pwm_cmd_b(cmd_b),
    .pwm_cmd_c(cmd_c), .pwm_cmd_d(cmd_d), .pfm_word(pfm_word), .phase_gate(gate), .aux_pulse(aux_pulse),
    .aux_dir(aux_dir), .adc_clk(adc_clk), .adc_strobe(adc_strobe), .adc_data_a(dat_a), .adc_data_b(dat_b),
    .feedback_a(fb_a), .feedback_b(fb_b), .feedback_valid(feedback_valid), .timer_count_value(tmr),
    .servo_latched_position(pos));
  apw_adc_model i_apw_adc_model (.adc_clk(adc_clk), .frame_start(ms_start), .skip(ac.sampler_leading_skip),
    .smp_a(SMP_A), .smp_b(SMP_B), .adc_data_a(dat_a), .adc_data_b(dat_b));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wrap_up();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic t_adc(input logic [2:0] dv, input logic [7:0] lag, input logic pair, conv, input logic [3:0] skp);
    int k, lat, fst, lst, n;
    logic [23:0] sw;
    logic pk;
    logic [15:0] ea, eb;
    ac.sampler_bitclock_divider = dv;
    ac.sampler_strobe_lag = lag;
    ac.sampler_sign_convert = conv;
    ac.sampler_leading_skip = skp;
    cc.feedback_pairing_enable = pair;
    cc.command_pairing_enable = pair;
    lat = -1;
    n = 0;
    fst = 0;
    lst = 0;
    sw = '0;
    pk = 1'b0;
    phase_tick = 1'b1;
    ms_start = 1'b1;
    cyc(1);
    phase_tick = 1'b0;
    ms_start = 1'b0;
    for (k = 0; k < 2000 && feedback_valid !== 1'b1; k++) begin
      if (lat < 0 && adc_strobe === 1'b1) lat = k;
      if (adc_clk === 1'b1 && pk === 1'b0) begin
        sw = {sw[22:0], adc_strobe};
        if (n == 0) fst = k;
        lst = k;
        n++;
      end
      pk = adc_clk;
      cyc(1);
    end
    if (k >= 2000) begin
      err_total++;
      wrap_up();
    end
    ea = SMP_A ^ (conv ? SIGN_FLIP : 16'h0);
    eb = SMP_B ^ (conv ? SIGN_FLIP : 16'h0);
    chk(32'(lat), 32'(lag) + 32'h1);
    chk(32'(n), 32'h18);
    chk(32'(lst - fst), 32'(23 * (2 << (dv - 3))));
    chk({8'h0, sw}, {8'h0, ac.sampler_frame_word});
    chk(fb_a, pair ? {ea, eb} : {ea, 16'h0});
    chk(fb_b, {eb, 16'h0});
    $display("adc test done");
  endtask

  task automatic t_pwm(input logic [2:0] n, input logic [7:0] gap, input logic pair, pol, input logic [3:0] sel);
    int k, rises, run, mr, both, hic, gm;
    logic ph;
    cc.pwm_rate_multiplier = n;
    cc.switch_gap_time = gap;
    cc.command_pairing_enable = pair;
    cc.feedback_pairing_enable = pair;
    cc.phase_polarity_invert = {1'b0, pol};
    cc.phase_output_select = sel;
    cmd_a = pair ? 32'h0000_8001 : 32'h0;
    cmd_c = 32'h7fff_0000;
    rises = 0;
    both = 0;
    hic = 0;
    run = -1000;
    mr = 999;
    ph = 1'b1;
    gm = (gap * 5333 + 3999) / 4000;
    for (k = 0; k < 768; k++) begin
      phase_tick = (k % 64 == 0);
      if (k >= 256) begin
        if (gate[0] === {~pol, ~pol}) both++;
        if ((gate[2].hi ^ pol) === 1'b1) hic++;
        if ((gate[0].hi ^ pol) === 1'b1 && ph === 1'b0) rises++;
        if (gate[0] === {pol, pol}) run++;
        else begin
          if (run > 0 && run < mr) mr = run;
          run = 0;
        end
      end
      ph = gate[0].hi ^ pol;
      cyc(1);
    end
    phase_tick = 1'b0;
    chk(32'(both), 32'h0);
    if (sel[0]) chk(32'(rises), 32'h0);
    else begin
      chkb(rises >= 4 * (n + 1) - 1 && rises <= 4 * (n + 1) + 1, 1'b1);
      chkb(mr >= gm && mr <= gm + 1, 1'b1);
    end
    chkb(hic > 400, !pair);
    $display("pwm test done");
  endtask

  task automatic t_pfm(input logic [2:0] tf, input logic [3:0] qd, input logic pol, dinv, aux);
    int k, fl, ax;
    logic [31:0] t0, e0;
    logic pv, av;
    cc.phase_output_select = 4'h8;
    cc.phase_polarity_invert = {pol, 1'b0};
    cc.command_pairing_enable = 1'b0;
    cc.feedback_pairing_enable = 1'b0;
    pc = '{1'b0, dinv, tf, qd, aux};
    // Slow rate on B low shows up if the wrong source is used
    cmd_b = 32'h0000_0001;
    servo_tick = 1'b1;
    cyc(1);
    servo_tick = 1'b0;
    cyc(3);
    t0 = tmr;
    e0 = pos;
    pfm_word = 32'h1000_0000;
    fl = 0;
    ax = 0;
    pv = gate[3].hi ^ pol;
    av = aux_pulse;
    for (k = 0; k < 400; k++) begin
      if (k == 380) pfm_word = 32'h0;
      if (pv === 1'b1 && (gate[3].hi ^ pol) === 1'b0) fl++;
      if (aux_pulse === 1'b1 && av === 1'b0) ax++;
      if (k == 200) chkb(gate[3].lo, ~dinv);
      pv = gate[3].hi ^ pol;
      av = aux_pulse;
      cyc(1);
    end
    servo_tick = 1'b1;
    cyc(1);
    servo_tick = 1'b0;
    cyc(3);
    chkb(fl > 20, 1'b1);
    chk(tmr - t0, tf == 3 ? 32'(fl) : 32'h0);
    chk(pos - e0, qd == 8 ? 32'(fl) << 8 : 32'h0);
    chk({24'h0, pos[7:0]}, 32'h80);
    chkb(ax > 0, aux);
    $display("pfm test done");
  endtask

  // Quadrature, negative rate, with a clock-enable freeze in the middle
  task automatic t_quad();
    int k, tg, dbl, ax, frz;
    logic [31:0] t0;
    logic [1:0] pq;
    cc.phase_polarity_invert = 2'h0;
    pc = '{1'b1, 1'b0, 3'h3, 4'h8, 1'b1};
    cyc(3);
    t0 = tmr;
    pq = gate[3];
    tg = 0;
    dbl = 0;
    ax = 0;
    frz = 0;
    pfm_word = 32'hf000_0000;
    for (k = 0; k < 220; k++) begin
      if (k == 200) pfm_word = 32'h0;
      if (gate[3] !== pq) begin
        tg++;
        if (k > 100 && k <= 140) frz++;
      end
      if (gate[3] === ~pq) dbl++;
      if ({aux_pulse, aux_dir} !== gate[3]) ax++;
      ce = (k < 100 || k >= 140);
      pq = gate[3];
      cyc(1);
    end
    cyc(3);
    chkb(tg > 6, 1'b1);
    chk(32'(dbl), 32'h0);
    chk(32'(frz), 32'h0);
    chk(t0 - tmr, 32'(tg));
    chk(32'(ax), 32'h0);
    $display("quadrature test done");
  endtask

  initial begin
    {rstn, phase_tick, servo_tick, ms_start} = 4'h0;
    ce = 1'b1;
    cc = '0;
    ac = '0;
    pc = '0;
    ac.sampler_frame_word = 24'hfffffe;
    {cmd_a, cmd_b, cmd_c, cmd_d, pfm_word} = '0;
    err_total = 0;
    checks = 0;
    cyc(11);
    chk({23'h0, gate, adc_strobe}, 32'h0);
    chk(tmr, 32'h0);
    cyc(1);
    rstn = 1'b1;
    $display("reset test done");
    t_adc(3'h4, 8'h0, 1'b1, 1'b0, 4'h1);
    t_adc(3'h5, 8'h3, 1'b0, 1'b1, 4'h2);
    t_pwm(3'h0, 8'h3, 1'b0, 1'b0, 4'h0);
    t_pwm(3'h3, 8'h6, 1'b1, 1'b1, 4'h8);
    t_pwm(3'h1, 8'h3, 1'b0, 1'b0, 4'h1);
    t_pfm(3'h3, 4'h0, 1'b0, 1'b1, 1'b1);
    t_pfm(3'h2, 4'h8, 1'b1, 1'b0, 1'b0);
    t_quad();
    wrap_up();
  end
endmodule // apw_axis_channel_bench
